//--- dv/ctm_timer_tb.sv
// Self-checking bench for the clock timer: reset values, gates, counting,
// high nibble latch, run, stop and clear, and interrupt flags and masks.
// Assumes the design takes bus strobes on rising edges; bench drives on
// falling edges.
`timescale 1ns/1ps
module ctm_timer_tb
	import ctm_pkg::*;
;
	// ------------------------------------------------------------
	// Signals and instance
	// ------------------------------------------------------------
	logic ref_clk, rst_n, crystal_oscillator, irq_req;
	ctm_bus_t bus_req;
	logic [3:0] rdata, got;
	logic multiplier_clock_gate, sound_clock_gate, stopwatch_clock_gate;
	int errors, checks, cyc;
	logic [7:0] cnt;
	logic run, gate;

	ctm_timer ctm_timer_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.crystal_oscillator(crystal_oscillator), .bus_req(bus_req),
		.rdata(rdata), .irq_req(irq_req),
		.multiplier_clock_gate(multiplier_clock_gate),
		.sound_clock_gate(sound_clock_gate),
		.stopwatch_clock_gate(stopwatch_clock_gate));

	// ------------------------------------------------------------
	// Compare, bus and tick tasks
	// ------------------------------------------------------------
	task automatic chk4(input string nm, input logic [3:0] e,
		input logic [3:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk4

	task automatic chk1(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask : chk1

	task automatic wr(input logic [15:0] a, input logic [3:0] d);
		@(negedge ref_clk);
		bus_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge ref_clk);
		bus_req.wr = 1'b0;
	endtask : wr

	// Read data holds until the next read, so sampling late is safe.
	task automatic rc(input logic [15:0] a, input logic [3:0] e,
		input string nm);
		@(negedge ref_clk);
		bus_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 4'h0};
		@(negedge ref_clk);
		bus_req.rd = 1'b0;
		@(negedge ref_clk);
		chk4(nm, e, rdata);
	endtask : rc

	// Low then high nibble in back to back reads, so the high value
	// must come from the latch taken by the low read.
	task automatic cc;
		@(negedge ref_clk);
		bus_req = '{addr: 16'hFF41, wr: 1'b0, rd: 1'b1, wdata: 4'h0};
		@(negedge ref_clk);
		got = rdata;
		bus_req.addr = 16'hFF42;
		@(negedge ref_clk);
		bus_req.rd = 1'b0;
		chk4("count_low", cnt[3:0], got);
		chk4("count_high", cnt[7:4], rdata);
	endtask : cc

	// Ticks come in whole groups of 128 so the prescaler phase stays zero.
	task automatic tk(input int n);
		repeat (n) begin
			@(negedge ref_clk);
			crystal_oscillator = 1'b1;
			@(negedge ref_clk);
			crystal_oscillator = 1'b0;
		end
		repeat (4) @(negedge ref_clk);
		if (run && gate) begin
			cnt += 8'(n / 128);
		end
	endtask : tk

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		logic [15:0] a [9];
		a = '{16'hFF16, 16'hFF40, 16'hFF41, 16'hFF42, 16'hFFEE,
			16'hFFEF, 16'hFFFE, 16'hFFFF, 16'hFF43};
		foreach (a[i]) begin
			rc(a[i], 4'h0, "reset_value");
		end
		chk1("irq_req", 1'b0, irq_req);
	endtask : t_reset

	task automatic t_gates;
		wr(16'hFF16, 4'hF);
		@(negedge ref_clk);
		chk1("mult_gate", 1'b1, multiplier_clock_gate);
		chk1("sound_gate", 1'b1, sound_clock_gate);
		chk1("sw_gate", 1'b1, stopwatch_clock_gate);
		wr(16'hFF16, 4'h1);
		rc(16'hFF16, 4'h1, "gates");
		chk1("mult_gate", 1'b0, multiplier_clock_gate);
		chk1("sound_gate", 1'b0, sound_clock_gate);
		chk1("sw_gate", 1'b0, stopwatch_clock_gate);
		gate = 1'b1;
	endtask : t_gates

	task automatic t_count_latch;
		wr(16'hFF40, 4'h1);
		run = 1'b1;
		rc(16'hFF40, 4'h1, "run_readback");
		tk(128 * 15);
		rc(16'hFF41, 4'hF, "count_low");
		tk(128);
		rc(16'hFF42, 4'h0, "latched_high");
		wr(16'hFF41, 4'h5);
		wr(16'hFF42, 4'h5);
		cc();
	endtask : t_count_latch

	task automatic t_stop_gate;
		wr(16'hFF40, 4'h0);
		run = 1'b0;
		tk(256);
		cc();
		wr(16'hFF16, 4'h0);
		gate = 1'b0;
		wr(16'hFF40, 4'h1);
		run = 1'b1;
		tk(256);
		cc();
		wr(16'hFF16, 4'h1);
		gate = 1'b1;
		tk(128);
		cc();
	endtask : t_stop_gate

	task automatic t_clear;
		wr(16'hFF40, 4'h3);
		cnt = 8'h00;
		rc(16'hFF40, 4'h1, "clear_reads_zero");
		tk(128 * 3);
		cc();
		wr(16'hFF40, 4'h2);
		run = 1'b0;
		cnt = 8'h00;
		tk(128);
		cc();
		wr(16'hFF40, 4'h1);
		run = 1'b1;
	endtask : t_clear

	// Wrap from FF to 00 drops every count bit at once.
	task automatic t_flags;
		tk(128 * 255);
		cc();
		wr(16'hFFFE, 4'hF);
		wr(16'hFFFF, 4'hF);
		rc(16'hFFFE, 4'h0, "flags_fast");
		rc(16'hFFFF, 4'h0, "flags_slow");
		tk(128);
		rc(16'hFFFE, 4'hF, "flags_fast");
		rc(16'hFFFF, 4'hF, "flags_slow");
		chk1("irq_req", 1'b0, irq_req);
		wr(16'hFFEF, 4'h8);
		rc(16'hFFEF, 4'h8, "mask_slow");
		chk1("irq_req", 1'b1, irq_req);
		wr(16'hFFFF, 4'h7);
		rc(16'hFFFF, 4'h8, "flags_slow");
		chk1("irq_req", 1'b1, irq_req);
		wr(16'hFFFF, 4'h8);
		rc(16'hFFEE, 4'h0, "mask_fast");
		chk1("irq_req", 1'b0, irq_req);
		wr(16'hFFEE, 4'h4);
		rc(16'hFFEE, 4'h4, "mask_fast");
		chk1("irq_req", 1'b1, irq_req);
		wr(16'hFFFE, 4'h4);
		rc(16'hFFFE, 4'hB, "flags_fast");
		chk1("irq_req", 1'b0, irq_req);
	endtask : t_flags

	// ------------------------------------------------------------
	// Verdict, clock, timeout and main sequence
	// ------------------------------------------------------------
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	// Clock of 25 ns period.
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// The whole run needs about 72000 cycles; a hang is cut off above it.
	initial begin
		cyc = 0;
		forever begin
			@(posedge ref_clk);
			cyc++;
			if (cyc == 95000) begin
				errors++;
				give_verdict();
			end
		end
	end

	// Main sequence after a 16 cycle reset.
	initial begin
		rst_n = 1'b0;
		crystal_oscillator = 1'b0;
		bus_req = '0;
		errors = 0;
		checks = 0;
		cnt = 8'h00;
		run = 1'b0;
		gate = 1'b0;
		repeat (16) @(negedge ref_clk);
		rst_n = 1'b1;
		t_reset();
		t_gates();
		t_count_latch();
		t_stop_gate();
		t_clear();
		t_flags();
		give_verdict();
	end
endmodule : ctm_timer_tb

//--- rtl/ctm_pkg.sv
// Types shared by the clock timer modules.
// Assumes ctm_regs.svh supplies the numeric constants.
package ctm_pkg;

	// CPU I/O access presented in one cycle.
	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [3:0] wdata;
	} ctm_bus_t;

	// Peripheral clock gate register, bit 3 down to bit 0.
	typedef struct packed {
		logic multiplier;
		logic sound;
		logic stopwatch;
		logic timer;
	} ctm_gates_t;

endpackage : ctm_pkg

//--- rtl/ctm_prescaler.sv
// Divide-by-128 prescaler turning crystal ticks into the 256 Hz enable.
// Assumes osc_tick is a one-cycle pulse per crystal period, synchronous.
`timescale 1ns/1ps
`include "ctm_regs.svh"
module ctm_prescaler
	import ctm_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Crystal tick and gate.
	input wire logic osc_tick,
	input wire logic timer_clock_gate,
	// Divided rate enable.
	output logic rate_tick
);

	logic [6:0] prescale;

	// Prescaler is held at zero while gated off, so a restart gives a
	// full first period instead of a stale partial one.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prescale <= `CTM_DIV_RST;
		end else if (!timer_clock_gate) begin
			prescale <= `CTM_DIV_RST;
		end else if (osc_tick) begin
			prescale <= prescale + `CTM_DIV_STEP;
		end
	end

	// One pulse on every 128th crystal tick while the gate is open.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rate_tick <= 1'b0;
		end else begin
			rate_tick <= timer_clock_gate && osc_tick &&
				(prescale == `CTM_DIV_LAST);
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_tick_needs_gate;
		rate_tick |-> $past(timer_clock_gate) && $past(osc_tick);
	endproperty
	a_tick_needs_gate: assert property (p_tick_needs_gate)
		else $error("Rate tick without open gate.");

	property p_tick_period;
		rate_tick |-> prescale == `CTM_DIV_RST;
	endproperty
	a_tick_period: assert property (p_tick_period)
		else $error("Rate tick not at prescaler wrap.");

	c_tick: cover property (rate_tick);

endmodule : ctm_prescaler

//--- rtl/ctm_regs.svh
// Register map, field positions and reset values of the 256 Hz clock timer.
// Assumes a 4-bit CPU data bus and a 16-bit I/O address.
//
// Overview of operation
// - Timer rate is the crystal oscillator divided by 128, giving 256 Hz.
// - Timer clock gate supplies the rate when one, stops it when zero.
// - The core is an 8-bit binary counter stepped by the divided clock.
// - Low nibble holds 128 to 16 Hz bits, high nibble 8 to 1 Hz.
// - Carry passes from low nibble into high nibble as one binary count.
// - Reading the low nibble latches the high nibble for later reads.
// - Count nibbles are read-only, writes ignored, zero after reset.
// - Each rate bit falling edge sets its flag and may request interrupt; here a clear write zeroes the count without setting any flag.
// - Flags set regardless of mask; mask gates only the request.
// - Eight mask bits enable when one; all clear at reset.
// - Run bit one advances, zero stops; readable; clears at reset.
// - Writing one to clear bit zeroes counter; reads as zero always.
// - Stopped counter holds; clear while running restarts from zero.
// - Writing one clears a flag, zero leaves it; flags clear at reset.
`ifndef CTM_REGS_SVH
`define CTM_REGS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define CTM_ADDR_GATES 16'hFF16
`define CTM_ADDR_CTRL 16'hFF40
`define CTM_ADDR_CNT_LO 16'hFF41
`define CTM_ADDR_CNT_HI 16'hFF42
`define CTM_ADDR_MASK_FAST 16'hFFEE
`define CTM_ADDR_MASK_SLOW 16'hFFEF
`define CTM_ADDR_FLAG_FAST 16'hFFFE
`define CTM_ADDR_FLAG_SLOW 16'hFFFF

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CTM_RUN_BIT 0
`define CTM_CLR_BIT 1
`define CTM_NIB_RST 4'h0
`define CTM_CNT_RST 8'h00
`define CTM_CNT_ONE 8'h01
`define CTM_DIV_RST 7'h00
`define CTM_DIV_LAST 7'h7F
`define CTM_DIV_STEP 7'h01
`define CTM_CTRL_PAD 3'h0
`define CTM_FLAG_NONE 8'h00

`endif

//--- rtl/ctm_timer.sv
// Clock timer: 8-bit count at 256 Hz, nibble reads with high latch,
// run and clear control, eight per-rate interrupt flags with masks.
// Assumes one CPU access per cycle on bus_req, reads answered next cycle.
`timescale 1ns/1ps
`include "ctm_regs.svh"
module ctm_timer
	import ctm_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Crystal oscillator tick, one cycle per crystal period.
	input wire logic crystal_oscillator,
	// CPU I/O access.
	input wire ctm_bus_t bus_req,
	output logic [3:0] rdata,
	// Interrupt request and neighbour clock gates.
	output logic irq_req,
	output logic multiplier_clock_gate,
	output logic sound_clock_gate,
	output logic stopwatch_clock_gate
);

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------

	// Matches one register address; shared by read and write decode.
	function automatic logic ctm_hit(input logic [15:0] a,
		input logic [15:0] target);
		ctm_hit = (a == target);
	endfunction : ctm_hit

	// Bits that go from one to zero between two count values.
	function automatic logic [7:0] ctm_falls(input logic [7:0] now,
		input logic [7:0] nxt);
		ctm_falls = now & ~nxt;
	endfunction : ctm_falls

	ctm_gates_t gates;
	logic timer_run_bit;
	logic [7:0] count_bits;
	logic [3:0] high_latch;
	logic [7:0] per_rate_irq_masks;
	logic [7:0] per_rate_irq_flags;
	logic rate_tick;
	logic wr_ctrl;
	logic clear_wr;
	logic step;
	logic [7:0] next_count;
	logic [7:0] fall_evt;
	logic [7:0] flag_clr;

	// Write strobes of the control register and the timer clear bit.
	assign wr_ctrl = bus_req.wr && ctm_hit(bus_req.addr, `CTM_ADDR_CTRL);
	assign clear_wr = wr_ctrl && bus_req.wdata[`CTM_CLR_BIT];
	assign step = rate_tick && timer_run_bit;

	// ------------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------------

	// The divider stands apart so the gate behaviour can be checked alone.
	ctm_prescaler ctm_prescaler_i (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.osc_tick(crystal_oscillator),
		.timer_clock_gate(gates.timer),
		.rate_tick(rate_tick)
	);

	// ------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------

	// Clear wins over a coincident step; the count then starts from zero
	// on the next tick if running, or stays zero if stopped.
	always_comb begin
		next_count = count_bits;
		fall_evt = `CTM_FLAG_NONE;
		if (clear_wr) begin
			next_count = `CTM_CNT_RST;
		end else if (step) begin
			next_count = count_bits + `CTM_CNT_ONE;
			fall_evt = ctm_falls(count_bits, next_count);
		end
	end

	// Counter register; bus writes to the count addresses never reach it.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_bits <= `CTM_CNT_RST;
		end else begin
			count_bits <= next_count;
		end
	end

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------

	// Run bit; the clear bit has no storage and so always reads zero.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_run_bit <= 1'b0;
		end else if (wr_ctrl) begin
			timer_run_bit <= bus_req.wdata[`CTM_RUN_BIT];
		end
	end

	// Peripheral clock gates, one bit per neighbouring block, and bit 0 for this timer.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gates <= ctm_gates_t'(`CTM_NIB_RST);
		end else if (bus_req.wr && ctm_hit(bus_req.addr, `CTM_ADDR_GATES)) begin
			gates <= ctm_gates_t'(bus_req.wdata);
		end
	end

	// Interrupt masks, fast rates in the low half.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			per_rate_irq_masks <= `CTM_CNT_RST;
		end else if (bus_req.wr) begin
			if (ctm_hit(bus_req.addr, `CTM_ADDR_MASK_FAST)) begin
				per_rate_irq_masks[3:0] <= bus_req.wdata;
			end
			if (ctm_hit(bus_req.addr, `CTM_ADDR_MASK_SLOW)) begin
				per_rate_irq_masks[7:4] <= bus_req.wdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// Interrupt flags
	// ------------------------------------------------------------------

	// Write-one-to-clear strobes for the two flag nibbles.
	always_comb begin
		flag_clr = `CTM_FLAG_NONE;
		if (bus_req.wr && ctm_hit(bus_req.addr, `CTM_ADDR_FLAG_FAST)) begin
			flag_clr[3:0] = bus_req.wdata;
		end
		if (bus_req.wr && ctm_hit(bus_req.addr, `CTM_ADDR_FLAG_SLOW)) begin
			flag_clr[7:4] = bus_req.wdata;
		end
	end

	// A new edge beats a clear in the same cycle so no event is lost.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			per_rate_irq_flags <= `CTM_CNT_RST;
		end else begin
			per_rate_irq_flags <= (per_rate_irq_flags & ~flag_clr) |
				fall_evt;
		end
	end

	// Request follows any enabled flag; masks never touch the flags.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= |(per_rate_irq_flags & per_rate_irq_masks);
		end
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------

	// High nibble latch; a read of the low nibble snapshots it so that a
	// carry between the two reads cannot tear the value.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			high_latch <= `CTM_NIB_RST;
		end else if (bus_req.rd &&
			ctm_hit(bus_req.addr, `CTM_ADDR_CNT_LO)) begin
			high_latch <= count_bits[7:4];
		end
	end

	// Read data register; unmapped addresses return zero.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= `CTM_NIB_RST;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				`CTM_ADDR_GATES: rdata <= gates;
				`CTM_ADDR_CTRL: rdata <= {`CTM_CTRL_PAD, timer_run_bit};
				`CTM_ADDR_CNT_LO: rdata <= count_bits[3:0];
				`CTM_ADDR_CNT_HI: rdata <= high_latch;
				`CTM_ADDR_MASK_FAST: rdata <= per_rate_irq_masks[3:0];
				`CTM_ADDR_MASK_SLOW: rdata <= per_rate_irq_masks[7:4];
				`CTM_ADDR_FLAG_FAST: rdata <= per_rate_irq_flags[3:0];
				`CTM_ADDR_FLAG_SLOW: rdata <= per_rate_irq_flags[7:4];
				default: rdata <= `CTM_NIB_RST;
			endcase
		end
	end

	// Gate outputs for the neighbouring blocks.
	assign multiplier_clock_gate = gates.multiplier;
	assign sound_clock_gate = gates.sound;
	assign stopwatch_clock_gate = gates.stopwatch;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_step;
		rate_tick && timer_run_bit && !clear_wr |=>
			count_bits == $past(count_bits) + `CTM_CNT_ONE;
	endproperty
	a_step: assert property (p_step)
		else $error("Counter did not step by one.");

	property p_hold;
		!rate_tick && !clear_wr |=> $stable(count_bits);
	endproperty
	a_hold: assert property (p_hold)
		else $error("Counter moved without a tick.");

	property p_stop;
		!timer_run_bit && !clear_wr |=> $stable(count_bits);
	endproperty
	a_stop: assert property (p_stop)
		else $error("Stopped counter changed.");

	property p_clear;
		clear_wr |=> count_bits == `CTM_CNT_RST;
	endproperty
	a_clear: assert property (p_clear)
		else $error("Clear did not zero the counter.");

	property p_ctrl_read;
		bus_req.rd && bus_req.addr == `CTM_ADDR_CTRL |=>
			rdata[3:1] == `CTM_CTRL_PAD &&
			rdata[0] == $past(timer_run_bit);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read)
		else $error("Control register read wrong.");

	property p_latch;
		bus_req.rd && bus_req.addr == `CTM_ADDR_CNT_LO ##1
			bus_req.rd && bus_req.addr == `CTM_ADDR_CNT_HI |=>
			rdata == $past(count_bits[7:4], 2);
	endproperty
	a_latch: assert property (p_latch)
		else $error("High nibble not from latch.");

	property p_flag_set;
		fall_evt != 8'h00 |=>
			(per_rate_irq_flags & $past(fall_evt)) == $past(fall_evt);
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("Falling edge did not set its flag.");

	property p_fall_bits;
		step && !clear_wr && count_bits[0] |-> fall_evt[0];
	endproperty
	a_fall_bits: assert property (p_fall_bits)
		else $error("128 Hz falling edge missed.");

	property p_w1c;
		flag_clr[0] && !fall_evt[0] |=> !per_rate_irq_flags[0];
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("Flag not cleared by writing one.");

	property p_irq;
		irq_req |-> $past(|(per_rate_irq_flags & per_rate_irq_masks));
	endproperty
	a_irq: assert property (p_irq)
		else $error("Request without an enabled flag.");

	c_wrap: cover property (step && count_bits == 8'hFF);
	c_clear_run: cover property (clear_wr && timer_run_bit);
	c_irq: cover property (irq_req);
	c_set_clear: cover property (|(fall_evt & flag_clr));

endmodule : ctm_timer
